// file: inc/psi_defs.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * physical-layer pin and strap block.
 * Assumes a 25 MHz system clock and byte addresses on the register port.
 */
`ifndef PSI_DEFS_SVH
`define PSI_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PSI_ADDR_W            8
`define PSI_DATA_W            32
`define PSI_OFF_CONFIG0       8'h00
`define PSI_OFF_STATUS        8'h04

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PSI_CFG_MODE_LSB      0
`define PSI_CFG_MODE_RST      2'h0
`define PSI_ST_IFSEL_LSB      0
`define PSI_ST_CLKSEL_LSB     2
`define PSI_ST_FAULT_BIT      4
`define PSI_ST_GUARD_LSB      5
`define PSI_ST_VIOL_LSB       7
`define PSI_MODE_RS485        2'h1
`define PSI_CLKSEL_OFF        2'h0
`define PSI_CLKSEL_4MHZ       2'h1
`define PSI_CLKSEL_10MHZ      2'h2
`define PSI_IFSEL_MAX_OK      2'h1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PSI_SYS_CLK_KHZ       25000
`define PSI_SYS_CLK_PS        40000
`define PSI_CRYSTAL_DRIVE_PIN_KHZ          40000
`define PSI_EXT_CLOCK_OUT_4_KHZ      4000
`define PSI_EXT_CLOCK_OUT_10_KHZ     10000
`define PSI_SETTLE_UT         8
`define PSI_UT_PS             (1000000000 / `PSI_CRYSTAL_DRIVE_PIN_KHZ)
`define PSI_HALF_OF(f)        (((`PSI_SYS_CLK_KHZ / (2 * (f))) < 1) ? 1 : \
                               (`PSI_SYS_CLK_KHZ / (2 * (f))))
`define PSI_SETTLE_CYC        (((`PSI_SETTLE_UT * `PSI_UT_PS) / `PSI_SYS_CLK_PS) < 1 ? 1 : \
                               ((`PSI_SETTLE_UT * `PSI_UT_PS) / `PSI_SYS_CLK_PS))

`endif

// file: inc/psi_pkg.sv
/*
 * Types of the physical-layer pin and strap block.
 * Assumes nothing beyond a SystemVerilog elaborator.
 */
package psi_pkg;

    // ------------------------------------------------------------
    // Controller reset, run and halt states
    // ------------------------------------------------------------
    typedef enum logic [3:0]
    {
        PSI_ST_POR  = 4'b0001,
        PSI_ST_HARD = 4'b0010,
        PSI_ST_RUN  = 4'b0100,
        PSI_ST_HALT = 4'b1000
    } psi_state_type;

endpackage

// file: inc/psi_ext_clock_out_if.sv
/*
 * Carrier between the pin block and its clock output generator.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps

interface psi_ext_clock_out_if;
    logic       run;
    logic       restart;
    logic [1:0] sel;
    logic       clk_out;

    modport ctrl (output run, output restart, output sel, input clk_out);
    modport gen  (input run, input restart, input sel, output clk_out);
endinterface

// file: rtl/psi_ext_clock_out_gen.sv
/*
 * Continuous clock output generator: a counter divides the system clock
 * by a half period floored from the selected rate, at least one cycle, or holds the output low when switched off.
 * Assumes restart is a one-cycle pulse and run low means internal reset.
 */
`timescale 1ns/1ps
`include "psi_defs.svh"

module psi_ext_clock_out_gen #(
    parameter int CNT_W = 8
) (
    input  wire logic   SYS_CLK,
    input  wire logic   SRST,
    psi_ext_clock_out_if.gen   cko
);
    localparam logic [CNT_W-1:0] HALF_4  = CNT_W'(`PSI_HALF_OF(`PSI_EXT_CLOCK_OUT_4_KHZ));
    localparam logic [CNT_W-1:0] HALF_10 = CNT_W'(`PSI_HALF_OF(`PSI_EXT_CLOCK_OUT_10_KHZ));
    localparam logic [CNT_W-1:0] HALF_40 = CNT_W'(`PSI_HALF_OF(`PSI_CRYSTAL_DRIVE_PIN_KHZ));

    if (CNT_W < 2 || `PSI_HALF_OF(`PSI_EXT_CLOCK_OUT_4_KHZ) >= (1 << CNT_W))
    begin : g_bad_cnt_w
        $error("psi_ext_clock_out_gen: CNT_W too small");
    end

    logic [1:0]       sel_r;
    logic [CNT_W-1:0] cnt_r;
    logic             clk_r;
    wire  [CNT_W-1:0] half_len;
    wire              cnt_end;
    wire              off;

    // ------------------------------------------------------------
    // Rate selection
    // ------------------------------------------------------------
    assign half_len = (sel_r == `PSI_CLKSEL_4MHZ)  ? HALF_4 :
                      (sel_r == `PSI_CLKSEL_10MHZ) ? HALF_10 : HALF_40;
    assign off      = (sel_r == `PSI_CLKSEL_OFF) || !cko.run;
    assign cnt_end  = (cnt_r >= half_len - CNT_W'(1));
    assign cko.clk_out = clk_r;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
            sel_r <= `PSI_CLKSEL_OFF;
        else if (cko.restart)
            sel_r <= cko.sel;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SRST || cko.restart || off || cnt_end)
            cnt_r <= '0;
        else
            cnt_r <= cnt_r + CNT_W'(1);
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SRST || off)
            clk_r <= 1'b0;
        else if (cnt_end && !cko.restart)
            clk_r <= !clk_r;
    end

endmodule // psi_ext_clock_out_gen

// file: rtl/psi_pin_strap.sv
/*
 * Physical-layer pin logic of the communication controller: transmit
 * enables and data for two channels, guardian enable sampling, strap
 * capture on the shared channel-1 data pin, clock output, reset state
 * and host interrupt line.
 * Assumes pins arrive asynchronously and the pad resolves the enables.
 */
// The implementer's own choices: the strobed register port and the address map.
// Function
// - Native mode drives one active-low transmit enable per channel.
// - RS485 mode uses the same two pins as active-low RS485 enables.
// - Two-bit bus driver mode field selects native or RS485 data.
// - Separate transmit data pin per channel in both modes.
// - Channel-1 data pin is an input during reset; capture interface select bit1.
// - While capturing, channel-1 driver off and pulldown on.
// - Sample one guardian enable input per channel to monitor schedule.
// - RS485 mode ignores guardian inputs; far side ties them to a level.
// - Continuous clock output with rate chosen by two straps.
// - Clock output stays active in all states but power-on reset, hard reset included.
// - Clock output may stop during power-on and low-voltage resets.
// - External reset is active low and sets a known startup state.
// - Host interrupt is a level: low asserted, high negated.
// - Device clock comes from the crystal or clock input, 40 MHz nominal.
// - Clock straps select off, 4, 10 or 40 MHz; from the 25 MHz system clock the divider gives 4.17, 12.5 and 12.5 MHz.
// - Unsupported interface code halts, ignores host, waits for hard reset.
// - All interrupt sources combine onto the one level-sensitive line.
// - Clock output settles within 8 microticks after hard reset release.
`timescale 1ns/1ps
`include "psi_defs.svh"

module psi_pin_strap #(
    parameter int N_IRQ = 4
) (
    input  wire logic                   SYS_CLK,
    input  wire logic                   SRST,
    input  wire logic [`PSI_ADDR_W-1:0] REG_ADDR,
    input  wire logic [`PSI_DATA_W-1:0] REG_WDATA,
    input  wire logic                   REG_WR,
    input  wire logic                   REG_RD,
    output logic      [`PSI_DATA_W-1:0] REG_RDATA,
    input  wire logic                   EXT_RESET_N,
    input  wire logic                   POR_RESET,
    input  wire logic [1:0]             CLK_SEL_STRAP,
    input  wire logic                   HOST_IF_STRAP_BIT0,
    input  wire logic [1:0]             GUARDIAN_ENABLE_IN,
    input  wire logic [1:0]             TX_REQ,
    input  wire logic [1:0]             TX_BIT,
    input  wire logic [N_IRQ-1:0]       IRQ_SOURCES,
    output logic      [1:0]             PHY_TX_ENABLE_N,
    output logic      [1:0]             PHY_TX_DATA_O,
    output logic      [1:0]             PHY_TX_DATA_OE,
    input  wire logic                   PHY_TX_DATA_I,
    output logic                        PHY_TX_DATA_PULLDOWN,
    output logic                        EXT_CLOCK_OUT,
    output logic                        HOST_IRQ_N,
    output logic      [1:0]             HOST_IF_SEL,
    output logic                        IF_SEL_FAULT,
    output logic                        CTRL_IN_RESET
);
    localparam int N_PIN      = 8;
    localparam int SETTLE_MAX = `PSI_SETTLE_CYC;

    if (N_IRQ < 1 || N_IRQ > 32)
    begin : g_bad_n_irq
        $error("psi_pin_strap: N_IRQ must be 1 to 32");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    wire  [N_PIN-1:0] pin_raw;
    logic [N_PIN-1:0] pin_f;

    assign pin_raw = {POR_RESET, PHY_TX_DATA_I, HOST_IF_STRAP_BIT0,
                      CLK_SEL_STRAP, GUARDIAN_ENABLE_IN, EXT_RESET_N};

    genvar gi;
    generate
        for (gi = 0; gi < N_PIN; gi++)
        begin : g_sync
            logic s1_r;
            logic s2_r;
            logic s3_r;
            always_ff @(posedge SYS_CLK)
            begin
                if (SRST)
                begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                end
                else
                begin
                    s1_r <= pin_raw[gi];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                end
            end
            always_ff @(posedge SYS_CLK)
            begin
                if (SRST)
                    pin_f[gi] <= 1'b0;
                else if (s2_r == s3_r)
                    pin_f[gi] <= s3_r;
            end
        end
    endgenerate

    wire       ext_rst_n_f = pin_f[0];
    wire [1:0] guard_f     = pin_f[2:1];
    wire [1:0] clksel_f    = pin_f[4:3];
    wire [1:0] ifsel_f     = pin_f[6:5];
    wire       por_f       = pin_f[7];

    // ------------------------------------------------------------
    // Reset sequence and strap capture
    // ------------------------------------------------------------
    psi_pkg::psi_state_type state_r;
    psi_pkg::psi_state_type state_nxt;
    logic [1:0]             ifsel_r;
    logic [1:0]             clksel_r;

    wire capture   = (state_r == psi_pkg::PSI_ST_POR) || (state_r == psi_pkg::PSI_ST_HARD);
    wire running   = (state_r == psi_pkg::PSI_ST_RUN);
    wire halted    = (state_r == psi_pkg::PSI_ST_HALT);
    wire if_bad    = (ifsel_r > `PSI_IFSEL_MAX_OK);
    wire releasing = capture && !por_f && ext_rst_n_f;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            psi_pkg::PSI_ST_POR,
            psi_pkg::PSI_ST_HARD:
            begin
                if (por_f)
                    state_nxt = psi_pkg::PSI_ST_POR;
                else if (!ext_rst_n_f)
                    state_nxt = psi_pkg::PSI_ST_HARD;
                else if (if_bad)
                    state_nxt = psi_pkg::PSI_ST_HALT;
                else
                    state_nxt = psi_pkg::PSI_ST_RUN;
            end
            psi_pkg::PSI_ST_RUN,
            psi_pkg::PSI_ST_HALT:
            begin
                if (por_f)
                    state_nxt = psi_pkg::PSI_ST_POR;
                else if (!ext_rst_n_f)
                    state_nxt = psi_pkg::PSI_ST_HARD;
            end
            default:
                state_nxt = psi_pkg::PSI_ST_POR;
        endcase
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
            state_r <= psi_pkg::PSI_ST_POR;
        else
            state_r <= state_nxt;
    end

    // Transparent while in reset, frozen at release
    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
        begin
            ifsel_r  <= 2'h0;
            clksel_r <= `PSI_CLKSEL_OFF;
        end
        else if (capture)
        begin
            ifsel_r  <= ifsel_f;
            clksel_r <= clksel_f;
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    logic [1:0]             mode_r;
    logic [1:0]             viol_r;
    logic [`PSI_DATA_W-1:0] rdata_r;

    wire host_ok   = !halted;
    wire hit_cfg   = (REG_ADDR == `PSI_OFF_CONFIG0);
    wire hit_stat  = (REG_ADDR == `PSI_OFF_STATUS);
    wire wr_cfg    = REG_WR && hit_cfg && host_ok;
    wire wr_stat   = REG_WR && hit_stat && host_ok;
    wire rs485     = (mode_r == `PSI_MODE_RS485);
    wire [1:0] viol_clr = wr_stat ? REG_WDATA[`PSI_ST_VIOL_LSB +: 2] : 2'h0;
    wire [1:0] viol_set = running && !rs485 ? (TX_REQ & ~guard_f) : 2'h0;

    wire [`PSI_DATA_W-1:0] cfg_word  = {{(`PSI_DATA_W-2){1'b0}}, mode_r};
    wire [`PSI_DATA_W-1:0] stat_word = {{(`PSI_DATA_W-9){1'b0}}, viol_r, guard_f,
                                        halted, clksel_r, ifsel_r};
    wire [`PSI_DATA_W-1:0] rd_mux    = !(REG_RD && host_ok) ? '0 :
                                       hit_cfg  ? cfg_word :
                                       hit_stat ? stat_word : '0;

    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
            mode_r <= `PSI_CFG_MODE_RST;
        else if (capture)
            mode_r <= `PSI_CFG_MODE_RST;
        else if (wr_cfg)
            mode_r <= REG_WDATA[`PSI_CFG_MODE_LSB +: 2];
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
            viol_r <= 2'h0;
        else
            viol_r <= (viol_r & ~viol_clr) | viol_set;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
            rdata_r <= '0;
        else
            rdata_r <= rd_mux;
    end

    // ------------------------------------------------------------
    // Transmit pins
    // ------------------------------------------------------------
    logic [1:0] txen_n_r;
    logic [1:0] txd_r;

    // RS485 ignores guardians; native needs the guardian window open
    wire [1:0] tx_go = running ? (TX_REQ & (rs485 ? 2'h3 : guard_f)) : 2'h0;

    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
        begin
            txen_n_r <= 2'h3;
            txd_r    <= 2'h3;
        end
        else
        begin
            txen_n_r <= ~tx_go;
            txd_r    <= (tx_go & TX_BIT) | ~tx_go;
        end
    end

    assign PHY_TX_ENABLE_N      = txen_n_r;
    assign PHY_TX_DATA_O        = txd_r;
    assign PHY_TX_DATA_OE       = {1'b1, !capture};
    assign PHY_TX_DATA_PULLDOWN = capture;

    // ------------------------------------------------------------
    // Clock output and interrupt
    // ------------------------------------------------------------
    psi_ext_clock_out_if cko ();
    logic irq_n_r;

    assign cko.run     = (state_r != psi_pkg::PSI_ST_POR);
    assign cko.restart = releasing;
    assign cko.sel     = clksel_f;

    psi_ext_clock_out_gen u_ext_clock_out (
        .SYS_CLK (SYS_CLK),
        .SRST    (SRST),
        .cko     (cko.gen)
    );

    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
            irq_n_r <= 1'b1;
        else
            irq_n_r <= !(running && (|IRQ_SOURCES));
    end

    assign EXT_CLOCK_OUT = cko.clk_out;
    assign HOST_IRQ_N    = irq_n_r;
    assign REG_RDATA     = rdata_r;
    assign HOST_IF_SEL   = ifsel_r;
    assign IF_SEL_FAULT  = halted;
    assign CTRL_IN_RESET = !running;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);

    sequence s_release;
        capture ##1 running;
    endsequence

    a_txen_idle_reset: assert property (!running |=> PHY_TX_ENABLE_N == 2'h3)
        else $error("transmit enable active outside run");
    a_strap_pin_float: assert property (capture |-> !PHY_TX_DATA_OE[0] && PHY_TX_DATA_PULLDOWN)
        else $error("strap pin driven during capture");
    a_strap_held_run: assert property (running ##1 running |-> $stable(ifsel_r) && $stable(clksel_r))
        else $error("strap value moved after release");
    a_rs485_no_guard: assert property (running && rs485 && TX_REQ[0] |=> !PHY_TX_ENABLE_N[0])
        else $error("rs485 enable blocked");
    a_native_guard_gate: assert property (running && !rs485 && TX_REQ[1] |=> PHY_TX_ENABLE_N[1] == !$past(guard_f[1]))
        else $error("guardian gate wrong");
    a_txd_follows_bit: assert property (running && tx_go[1] |=> PHY_TX_DATA_O[1] == $past(TX_BIT[1]))
        else $error("transmit data mismatch");
    a_irq_level_low: assert property (running && (|IRQ_SOURCES) |=> !HOST_IRQ_N)
        else $error("interrupt not asserted");
    a_halt_ignores_host: assert property (halted && REG_WR |=> $stable(mode_r))
        else $error("write taken while halted");
    a_clk_off_por: assert property ((state_r == psi_pkg::PSI_ST_POR) [*2] |-> !EXT_CLOCK_OUT)
        else $error("clock output running in power-on reset");
    a_clk_settle_release: assert property (s_release ##0 ($past(clksel_f, 1) != `PSI_CLKSEL_OFF)
        |-> ##[1:SETTLE_MAX] $changed(EXT_CLOCK_OUT))
        else $error("clock output did not settle");

endmodule // psi_pin_strap

// file: verification/psi_phy_model.sv
/*
 * Far-side model: two bus drivers with their guardians, and the strap
 * resistor on the shared channel-1 data pin.
 * Assumes the bench sets the strap pull and the guardian windows.
 */
`timescale 1ns/1ps

module psi_phy_model (
    input  wire logic       clk,
    input  wire logic       strap_up,
    input  wire logic [1:0] guard_open,
    input  wire logic [1:0] tx_data_o,
    input  wire logic [1:0] tx_data_oe,
    input  wire logic       pull_dn,
    output logic            tx_data_i,
    output logic      [1:0] guard_en
);
    logic last_r;

    // Guardian lines always held at a defined level
    assign guard_en = guard_open;
    // Driver first, then strap resistor, then pulldown, else floating
    assign tx_data_i = tx_data_oe[0] ? tx_data_o[0] :
                       strap_up ? 1'b1 : pull_dn ? 1'b0 : ~last_r;

    always_ff @(posedge clk)
    begin
        last_r <= tx_data_i;
    end
endmodule // psi_phy_model

// file: verification/phy_pin_strap_interface_tb_top.sv
/*
 * Self-checking bench of the pin and strap block with its far-side model.
 * Assumes a 25 MHz clock and straps applied while reset is held.
 */
`timescale 1ns/1ps
`include "psi_defs.svh"

module phy_pin_strap_interface_tb_top;
    logic        clk, srst, wr, rd, ext_n, por, bit0, strap_up;
    logic        tdi, pdn, cko, irq_n, fault, inrst;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, rnd, d;
    logic [1:0]  csel, gopen, treq, tbit, ten_n, tdo, toe, gen, ifsel;
    logic [1:0]  pq, pb, en, viol, old;
    logic [3:0]  irq, pi;
    int          failures, n_tests, h, f;

    psi_pin_strap uut (
        .SYS_CLK(clk), .SRST(srst), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .EXT_RESET_N(ext_n),
        .POR_RESET(por), .CLK_SEL_STRAP(csel), .HOST_IF_STRAP_BIT0(bit0),
        .GUARDIAN_ENABLE_IN(gen), .TX_REQ(treq), .TX_BIT(tbit),
        .IRQ_SOURCES(irq), .PHY_TX_ENABLE_N(ten_n), .PHY_TX_DATA_O(tdo),
        .PHY_TX_DATA_OE(toe), .PHY_TX_DATA_I(tdi), .PHY_TX_DATA_PULLDOWN(pdn),
        .EXT_CLOCK_OUT(cko), .HOST_IRQ_N(irq_n), .HOST_IF_SEL(ifsel),
        .IF_SEL_FAULT(fault), .CTRL_IN_RESET(inrst)
    );

    psi_phy_model phy (
        .clk(clk), .strap_up(strap_up), .guard_open(gopen), .tx_data_o(tdo),
        .tx_data_oe(toe), .pull_dn(pdn), .tx_data_i(tdi), .guard_en(gen)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Half period in cycles; 12 means the output never moved
    function automatic int exp_half(input logic [1:0] s);
        if (s == `PSI_CLKSEL_OFF)
            return 12;
        if (s == `PSI_CLKSEL_4MHZ)
            return `PSI_HALF_OF(`PSI_EXT_CLOCK_OUT_4_KHZ);
        if (s == `PSI_CLKSEL_10MHZ)
            return `PSI_HALF_OF(`PSI_EXT_CLOCK_OUT_10_KHZ);
        return `PSI_HALF_OF(`PSI_CRYSTAL_DRIVE_PIN_KHZ);
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test;
        if (failures == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic wait_rst(input logic lvl);
        int k;
        k = 0;
        while (inrst !== lvl && k < 50)
        begin
            @(posedge clk);
            #1 k++;
        end
        if (k >= 50)
        begin
            failures++;
            finish_test();
        end
    endtask

    // f: cycles to first change, h: cycles between two changes
    task automatic half(output int hh, output int ff);
        logic v;
        hh = 0;
        ff = 0;
        @(negedge clk);
        v = cko;
        while (cko === v && ff < 12)
        begin
            @(negedge clk);
            ff++;
        end
        v = cko;
        while (cko === v && hh < 12)
        begin
            @(negedge clk);
            hh++;
        end
    endtask

    task automatic hard_rst(input logic [1:0] cs, input logic b0, input logic b1);
        int k;
        ext_n <= 1'b0;
        tick(6);
        wait_rst(1'b1);
        half(h, f);
        chk("cko_hard", h, exp_half(old));
        csel <= cs;
        bit0 <= b0;
        strap_up <= b1;
        tick(4);
        ext_n <= 1'b1;
        k = 0;
        while (inrst !== 1'b0 && fault !== 1'b1 && k < 20)
        begin
            @(posedge clk);
            #1 k++;
        end
        if (k >= 20)
        begin
            failures++;
            finish_test();
        end
        old = cs;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial
    begin
        srst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        ext_n = 1'b1;
        por = 1'b0;
        csel = 2'h1;
        old = 2'h1;
        bit0 = 1'b0;
        strap_up = 1'b0;
        gopen = 2'h0;
        treq = 2'h0;
        tbit = 2'h0;
        irq = 4'h0;
        rnd = 32'h0000_001a;
        failures = 0;
        n_tests = 0;
        tick(8);
        #1;
        chk("ten_n_rst", ten_n, 2'h3);
        chk("oe_rst", toe, 2'h2);
        chk("pdn_rst", pdn, 1'b1);
        chk("irq_n_rst", irq_n, 1'b1);
        srst <= 1'b0;
        wait_rst(1'b0);
        chk("oe_run", toe, 2'h3);
        chk("pdn_run", pdn, 1'b0);
        for (int c = 0; c < 4; c++)
        begin
            hard_rst(c[1:0], c[0], 1'b0);
            chk("ifsel", ifsel, {1'b0, c[0]});
            half(h, f);
            chk("cko", h, exp_half(c[1:0]));
            chk("settle", (c == 0) || (f <= `PSI_SETTLE_CYC), 1'b1);
            csel <= ~c[1:0];
            bit0 <= ~c[0];
            tick(6);
            reg_rd(`PSI_OFF_STATUS, d);
            chk("strap", d[4:0], {1'b0, c[1:0], 1'b0, c[0]});
        end
        reg_rd(8'h40, d);
        chk("unmapped", d, 32'h0000_0000);
        for (int m = 0; m < 4; m++)
        begin
            reg_wr(`PSI_OFF_CONFIG0, m);
            reg_wr(`PSI_OFF_STATUS, 32'h0000_0180);
            reg_rd(`PSI_OFF_CONFIG0, d);
            chk("cfg", d, m);
            viol = 2'h0;
            for (int b = 0; b < 4; b++)
            begin
                rnd = xs(rnd);
                gopen <= rnd[1:0];
                tick(6);
                for (int k = 0; k < 12; k++)
                begin
                    @(posedge clk);
                    pq = treq;
                    pb = tbit;
                    pi = irq;
                    rnd = xs(rnd);
                    treq <= (k < 11) ? rnd[3:2] : 2'h0;
                    tbit <= rnd[5:4];
                    irq <= rnd[9:6];
                    @(negedge clk);
                    en = pq & ((m == `PSI_MODE_RS485) ? 2'h3 : gopen);
                    viol = viol | (pq & ~en);
                    chk("ten_n", ten_n, 2'(~en));
                    chk("tdo", tdo & en, pb & en);
                    chk("irq_n", irq_n, ~|pi);
                end
            end
            reg_rd(`PSI_OFF_STATUS, d);
            chk("guard", d[8:5], {viol, gopen});
        end
        hard_rst(old, 1'b0, 1'b1);
        tick(8);
        chk("fault", fault, 1'b1);
        chk("ifsel_bad", ifsel, 2'h2);
        treq <= 2'h3;
        gopen <= 2'h3;
        reg_rd(`PSI_OFF_STATUS, d);
        chk("halt_rd", d, 32'h0000_0000);
        reg_wr(`PSI_OFF_CONFIG0, 32'h0000_0001);
        chk("halt_tx", ten_n, 2'h3);
        treq <= 2'h0;
        hard_rst(old, 1'b0, 1'b0);
        chk("fault_clr", fault, 1'b0);
        reg_rd(`PSI_OFF_CONFIG0, d);
        chk("cfg_rst", d, `PSI_CFG_MODE_RST);
        por <= 1'b1;
        wait_rst(1'b1);
        half(h, f);
        chk("cko_por", h, 12);
        por <= 1'b0;
        wait_rst(1'b0);
        finish_test();
    end
endmodule // phy_pin_strap_interface_tb_top
